// file: logic/accel_config_test_regs.svh
`ifndef ACCEL_CONFIG_TEST_REGS_SVH
`define ACCEL_CONFIG_TEST_REGS_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define OFS_DEVICE_IDENTITY     8'h18
`define OFS_STARTUP_INIT_THREE  8'h1a
`define OFS_SCRATCHPAD          8'h1b
`define OFS_POWER_LEVEL_CONTROL 8'h1c
`define OFS_X_DRIVE_MOTION      8'h20
`define OFS_Y_DRIVE_MOTION      8'h21
`define OFS_Z_DRIVE_MOTION      8'h22

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define WAKE_LEVEL_LSB   0
`define WAKE_LEVEL_MSB   2
`define WATCH_LEVEL_LSB  4
`define WATCH_LEVEL_MSB  6
`define FAST_SERIAL_BIT  7
`define DRIVE_POS_BIT    2
`define DRIVE_NEG_BIT    3
`define GAIN_SELECT_BIT  0
`define WATCH_GAIN_BIT   7

// ----------------------------------------------------------------------
// Reset and fixed read values
// ----------------------------------------------------------------------
`define RST_BYTE         8'h00
`define Y_READ_ACTIVE    8'h80
`define Y_READ_IDLE      8'h00
`define UNMAPPED_READ    8'h00

`endif

// file: logic/accel_config_test_pkg.sv
package accel_config_test_pkg;

	typedef enum logic [2:0] {
		LEVEL_LOW        = 3'b000,
		LEVEL_ULTRA_LOW  = 3'b011,
		LEVEL_PRECISION  = 3'b100
	} power_level_t;

	typedef enum logic [2:0] {
		MODE_SLEEP    = 3'b000,
		MODE_STANDBY  = 3'b001,
		MODE_WATCH    = 3'b010,
		MODE_CONTINUOUS_WAKE_MODE    = 3'b101,
		MODE_COMBINED_WAKE_MODE    = 3'b110,
		MODE_TRIGGER  = 3'b111
	} mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic x_pos;
		logic x_neg;
		logic y_pos;
		logic y_neg;
		logic z_pos;
		logic z_neg;
	} drive_t;

	typedef struct packed {
		logic [2:0] wake_level;
		logic [2:0] watch_level;
		logic       fast_serial;
		logic       wake_reserved;
		logic       watch_reserved;
	} power_t;

	typedef struct packed {
		logic [7:0] init_three;
		logic [7:0] scratchpad;
		power_t     power;
		logic [7:0] x_motion;
		logic [7:0] y_motion;
		logic [7:0] z_motion;
		drive_t     drive;
		logic [7:0] rdata;
	} state_t;

endpackage

// file: logic/accel_config_test_regs.sv
// Contract
// - Read-only identity at 0x18, writes ignored
// - Scratchpad stores and returns any byte
// - Bits 2:0 pick wake power level
// - Bits 6:4 pick watch power level
// - Fast serial enable always reads zero
// - X drive bits 2 positive, 3 negative
// - Y reads 0x80 active, 0x00 idle
// - Y drive bits 2 positive, 3 negative
// - Z drive bits 2 positive, 3 negative
`timescale 1ns/100ps
`include "accel_config_test_regs.svh"

module accel_config_test_regs #(
	parameter logic [7:0] IDENTITY_CODE = 8'h5a // Arbitrary value
) (
	input  wire logic                          clk_in,
	input  wire logic                          rst_in,
	input  wire accel_config_test_pkg::reg_req_t req_in,
	input  wire accel_config_test_pkg::mode_t  mode_select_field_in,
	output logic [7:0]                         rdata_out,
	output accel_config_test_pkg::drive_t      drive_out,
	output logic [2:0]                         wake_power_level_out,
	output logic [2:0]                         watch_power_level_out,
	output logic                               fast_serial_enable_out,
	output logic                               wake_level_reserved_out,
	output logic                               watch_level_reserved_out,
	output logic                               analog_gain_select_out,
	output logic                               watch_wake_gain_bit_out,
	output logic [7:0]                         startup_init_out
);
	import accel_config_test_pkg::*;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Opposing drive would fight the proof mass; neither is applied.
	function automatic logic [1:0] axis_drive(input logic [7:0] b);
		logic p;
		logic n;
		p = b[`DRIVE_POS_BIT];
		n = b[`DRIVE_NEG_BIT];
		axis_drive = {n & ~p, p & ~n};
	endfunction

	function automatic logic level_reserved(input logic [2:0] code);
		logic r;
		r = 1'b1;
		if (code == LEVEL_LOW || code == LEVEL_ULTRA_LOW ||
			code == LEVEL_PRECISION)
		begin
			r = 1'b0;
		end
		level_reserved = r;
	endfunction

	function automatic logic mode_active(input mode_t m);
		logic a;
		a = 1'b0;
		unique case (m)
			MODE_WATCH,
			MODE_CONTINUOUS_WAKE_MODE,
			MODE_COMBINED_WAKE_MODE,
			MODE_TRIGGER:
				a = 1'b1;
			MODE_SLEEP,
			MODE_STANDBY:
				a = 1'b0;
			default:
				a = 1'b0;
		endcase
		mode_active = a;
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	state_t     state_reg;
	state_t     state_next;
	logic [1:0] x_pair;
	logic [1:0] y_pair;
	logic [1:0] z_pair;

	always_comb
	begin
		state_next = state_reg;
		if (req_in.wr)
		begin
			unique case (req_in.addr)
				`OFS_STARTUP_INIT_THREE:
					state_next.init_three = req_in.wdata;
				`OFS_SCRATCHPAD:
					state_next.scratchpad = req_in.wdata;
				`OFS_POWER_LEVEL_CONTROL:
				begin
					state_next.power.wake_level =
						req_in.wdata[`WAKE_LEVEL_MSB:`WAKE_LEVEL_LSB];
					state_next.power.watch_level =
						req_in.wdata[`WATCH_LEVEL_MSB:`WATCH_LEVEL_LSB];
					state_next.power.fast_serial =
						req_in.wdata[`FAST_SERIAL_BIT];
				end
				`OFS_X_DRIVE_MOTION:
					state_next.x_motion = req_in.wdata;
				`OFS_Y_DRIVE_MOTION:
					state_next.y_motion = req_in.wdata;
				`OFS_Z_DRIVE_MOTION:
					state_next.z_motion = req_in.wdata;
				default:
				begin
					// Identity and unmapped offsets take no write
				end
			endcase
		end

		state_next.power.wake_reserved =
			level_reserved(state_next.power.wake_level);
		state_next.power.watch_reserved =
			level_reserved(state_next.power.watch_level);

		x_pair = axis_drive(state_next.x_motion);
		y_pair = axis_drive(state_next.y_motion);
		z_pair = axis_drive(state_next.z_motion);
		state_next.drive.x_pos = x_pair[0];
		state_next.drive.x_neg = x_pair[1];
		state_next.drive.y_pos = y_pair[0];
		state_next.drive.y_neg = y_pair[1];
		state_next.drive.z_pos = z_pair[0];
		state_next.drive.z_neg = z_pair[1];

		// Read data stand only in the cycle after the strobe
		state_next.rdata = `UNMAPPED_READ;
		if (req_in.rd)
		begin
			unique case (req_in.addr)
				`OFS_DEVICE_IDENTITY:
					state_next.rdata = IDENTITY_CODE;
				`OFS_STARTUP_INIT_THREE:
					state_next.rdata = state_reg.init_three;
				`OFS_SCRATCHPAD:
					state_next.rdata = state_reg.scratchpad;
				`OFS_POWER_LEVEL_CONTROL:
				begin
					state_next.rdata = `RST_BYTE;
					state_next.rdata[`WAKE_LEVEL_MSB:`WAKE_LEVEL_LSB] =
						state_reg.power.wake_level;
					state_next.rdata[`WATCH_LEVEL_MSB:`WATCH_LEVEL_LSB] =
						state_reg.power.watch_level;
				end
				`OFS_Y_DRIVE_MOTION:
					state_next.rdata = mode_active(mode_select_field_in)
						? `Y_READ_ACTIVE : `Y_READ_IDLE;
				`OFS_Z_DRIVE_MOTION:
					state_next.rdata = state_reg.z_motion;
				default:
					// X is write-only and reads as zero
					state_next.rdata = `UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign rdata_out                = state_reg.rdata;
	assign drive_out                = state_reg.drive;
	assign wake_power_level_out     = state_reg.power.wake_level;
	assign watch_power_level_out    = state_reg.power.watch_level;
	assign fast_serial_enable_out   = state_reg.power.fast_serial;
	assign wake_level_reserved_out  = state_reg.power.wake_reserved;
	assign watch_level_reserved_out = state_reg.power.watch_reserved;
	assign analog_gain_select_out   = state_reg.x_motion[`GAIN_SELECT_BIT];
	assign watch_wake_gain_bit_out  = state_reg.y_motion[`WATCH_GAIN_BIT];
	assign startup_init_out         = state_reg.init_three;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	logic [7:0] scratchpad_shadow;
	logic       shadow_valid;

	// Shadow of the last scratchpad write, to check read-back
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			scratchpad_shadow <= `RST_BYTE;
			shadow_valid <= 1'b0;
		end
		else if (req_in.wr && req_in.addr == `OFS_SCRATCHPAD)
		begin
			scratchpad_shadow <= req_in.wdata;
			shadow_valid <= 1'b1;
		end
	end

	a_identity_read: assert property (
		req_in.rd && req_in.addr == `OFS_DEVICE_IDENTITY
		|=> rdata_out == IDENTITY_CODE)
		else $error("identity read wrong");

	a_scratchpad_back: assert property (
		req_in.rd && req_in.addr == `OFS_SCRATCHPAD
		|=> rdata_out == scratchpad_shadow)
		else $error("scratchpad read-back wrong");

	a_fast_serial_zero: assert property (
		req_in.rd && req_in.addr == `OFS_POWER_LEVEL_CONTROL
		|=> rdata_out[`FAST_SERIAL_BIT] == 1'b0 &&
			rdata_out[`WAKE_LEVEL_MSB:`WAKE_LEVEL_LSB] ==
			wake_power_level_out &&
			rdata_out[`WATCH_LEVEL_MSB:`WATCH_LEVEL_LSB] ==
			watch_power_level_out)
		else $error("power control read wrong");

	a_wake_level_write: assert property (
		req_in.wr && req_in.addr == `OFS_POWER_LEVEL_CONTROL
		|=> wake_power_level_out ==
			$past(req_in.wdata[`WAKE_LEVEL_MSB:`WAKE_LEVEL_LSB]) &&
			wake_level_reserved_out ==
			!(wake_power_level_out inside {LEVEL_LOW, LEVEL_ULTRA_LOW,
			LEVEL_PRECISION}))
		else $error("wake power level not taken");

	a_watch_level_write: assert property (
		req_in.wr && req_in.addr == `OFS_POWER_LEVEL_CONTROL
		|=> watch_power_level_out ==
			$past(req_in.wdata[`WATCH_LEVEL_MSB:`WATCH_LEVEL_LSB]) &&
			fast_serial_enable_out ==
			$past(req_in.wdata[`FAST_SERIAL_BIT]))
		else $error("watch power level not taken");

	a_y_read_mode: assert property (
		req_in.rd && req_in.addr == `OFS_Y_DRIVE_MOTION
		|=> rdata_out == ($past(mode_select_field_in) inside
			{MODE_WATCH, MODE_CONTINUOUS_WAKE_MODE, MODE_COMBINED_WAKE_MODE, MODE_TRIGGER}
			? `Y_READ_ACTIVE : `Y_READ_IDLE))
		else $error("Y read-back does not follow mode");

	a_x_drive_write: assert property (
		req_in.wr && req_in.addr == `OFS_X_DRIVE_MOTION &&
		req_in.wdata[`DRIVE_POS_BIT] && !req_in.wdata[`DRIVE_NEG_BIT]
		|=> drive_out.x_pos && !drive_out.x_neg
		##1 (drive_out.x_pos || $past(req_in.wr)))
		else $error("X positive drive not applied");

	a_y_drive_write: assert property (
		req_in.wr && req_in.addr == `OFS_Y_DRIVE_MOTION
		|=> drive_out.y_neg == ($past(req_in.wdata[`DRIVE_NEG_BIT]) &&
			!$past(req_in.wdata[`DRIVE_POS_BIT])))
		else $error("Y drive wrong");

	a_z_drive_write: assert property (
		req_in.wr && req_in.addr == `OFS_Z_DRIVE_MOTION
		|=> drive_out.z_pos == ($past(req_in.wdata[`DRIVE_POS_BIT]) &&
			!$past(req_in.wdata[`DRIVE_NEG_BIT])))
		else $error("Z drive wrong");

	a_conflict_off: assert property (
		!(drive_out.x_pos && drive_out.x_neg) &&
		!(drive_out.y_pos && drive_out.y_neg) &&
		!(drive_out.z_pos && drive_out.z_neg))
		else $error("opposing drive applied");

	a_read_one_cycle: assert property (
		!req_in.rd |=> rdata_out == `UNMAPPED_READ)
		else $error("read data outside read cycle");

	a_init_read: assert property (
		req_in.rd && req_in.addr == `OFS_STARTUP_INIT_THREE
		|=> rdata_out == startup_init_out)
		else $error("init register read wrong");

	a_x_write_only: assert property (
		req_in.rd && req_in.addr == `OFS_X_DRIVE_MOTION
		|=> rdata_out == `UNMAPPED_READ)
		else $error("X drive register not write-only");

	a_z_read_drive: assert property (
		req_in.rd && req_in.addr == `OFS_Z_DRIVE_MOTION
		|=> drive_out.z_pos == (rdata_out[`DRIVE_POS_BIT] &&
			!rdata_out[`DRIVE_NEG_BIT]) &&
			drive_out.z_neg == (rdata_out[`DRIVE_NEG_BIT] &&
			!rdata_out[`DRIVE_POS_BIT]))
		else $error("Z drive disagrees with read-back");

	a_y_gain_write: assert property (
		req_in.wr && req_in.addr == `OFS_Y_DRIVE_MOTION
		|=> watch_wake_gain_bit_out ==
			$past(req_in.wdata[`WATCH_GAIN_BIT]))
		else $error("Y bit 7 not stored");

	a_watch_reserved: assert property (
		watch_level_reserved_out == !(watch_power_level_out inside
			{LEVEL_LOW, LEVEL_ULTRA_LOW, LEVEL_PRECISION}))
		else $error("watch level reserved flag wrong");

	// Drive must not creep in cycles with no register write
	a_drive_hold: assert property (
		!req_in.wr |=> $stable(drive_out))
		else $error("drive changed without a write");

	a_power_hold: assert property (
		!(req_in.wr && req_in.addr == `OFS_POWER_LEVEL_CONTROL)
		|=> $stable(wake_power_level_out) &&
			$stable(watch_power_level_out) &&
			$stable(fast_serial_enable_out))
		else $error("power levels changed without a write");

	c_scratchpad_round: cover property (
		req_in.wr && req_in.addr == `OFS_SCRATCHPAD
		##1 req_in.rd && req_in.addr == `OFS_SCRATCHPAD && shadow_valid);

	c_y_active_read: cover property (
		req_in.rd && req_in.addr == `OFS_Y_DRIVE_MOTION &&
		mode_active(mode_select_field_in));

	c_x_conflict: cover property (
		req_in.wr && req_in.addr == `OFS_X_DRIVE_MOTION &&
		req_in.wdata[`DRIVE_POS_BIT] && req_in.wdata[`DRIVE_NEG_BIT]);

	c_reserved_level: cover property (wake_level_reserved_out);

	c_power_read: cover property (
		req_in.rd && req_in.addr == `OFS_POWER_LEVEL_CONTROL &&
		fast_serial_enable_out);

endmodule

// file: tb/accel_host_model.sv
`timescale 1ns/100ps
`include "accel_config_test_regs.svh"

module accel_host_model (
	input  wire logic                        clk_in,
	input  wire logic [7:0]                  rdata_in,
	output accel_config_test_pkg::reg_req_t  req_out
);
	import accel_config_test_pkg::*;

	logic [7:0] y_shadow;
	logic       fast_shadow; // Bit reads as zero, so software tracks it

	initial
	begin
		req_out = '0;
		y_shadow = 8'h00;
		fast_shadow = 1'b0;
	end

	// ------------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------------
	task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		req_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_in);
		req_out.wr <= 1'b0;
		#1;
	endtask

	task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		req_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_in);
		req_out.rd <= 1'b0;
		#1 d = rdata_in;
	endtask

	// ------------------------------------------------------------------
	// Software sequences, dir is {negative, positive}
	// ------------------------------------------------------------------
	task automatic write_y(input logic [1:0] dir);
		y_shadow = {4'h0, dir, 2'b00};
		write_byte(`OFS_Y_DRIVE_MOTION, y_shadow | 8'h80);
	endtask

	task automatic write_x(input logic [1:0] dir);
		write_byte(`OFS_X_DRIVE_MOTION, {4'h0, dir, 2'b01});
		write_byte(`OFS_Y_DRIVE_MOTION, y_shadow | 8'h80);
	endtask

	task automatic write_z(input logic [1:0] dir);
		write_byte(`OFS_Z_DRIVE_MOTION, {4'h0, dir, 2'b00});
	endtask

	task automatic write_power(input logic f, input logic [2:0] s,
		input logic [2:0] w);
		fast_shadow = f;
		write_byte(`OFS_POWER_LEVEL_CONTROL, {f, s, 1'b0, w});
	endtask

	task automatic start_up();
		write_byte(`OFS_STARTUP_INIT_THREE, 8'h00);
		write_x(2'b00);
	endtask
endmodule

// file: tb/accel_config_test_regs_tb_top.sv
`timescale 1ns/100ps

module accel_config_test_regs_tb_top;
	import accel_config_test_pkg::*;

	localparam logic [7:0] ID_CODE = 8'h3c; // Arbitrary value

	logic       clk_in = 1'b0;
	logic       rst_in = 1'b1;
	mode_t      mode_sel = MODE_SLEEP;
	reg_req_t   req;
	logic [7:0] rdata;
	logic [7:0] init_byte;
	drive_t     drive;
	logic [2:0] wake_lvl;
	logic [2:0] watch_lvl;
	logic       fast;
	logic       wake_rsv;
	logic       watch_rsv;
	logic       gain_sel;
	logic       wake_gain;
	int         fail_count = 0;
	int         samples_checked = 0;
	int         cycles = 0;

	always #5 clk_in = ~clk_in;

	accel_config_test_regs #(.IDENTITY_CODE(ID_CODE)) uut (
		.clk_in                   (clk_in),
		.rst_in                   (rst_in),
		.req_in                   (req),
		.mode_select_field_in     (mode_sel),
		.rdata_out                (rdata),
		.drive_out                (drive),
		.wake_power_level_out     (wake_lvl),
		.watch_power_level_out    (watch_lvl),
		.fast_serial_enable_out   (fast),
		.wake_level_reserved_out  (wake_rsv),
		.watch_level_reserved_out (watch_rsv),
		.analog_gain_select_out   (gain_sel),
		.watch_wake_gain_bit_out  (wake_gain),
		.startup_init_out         (init_byte)
	);

	accel_host_model host (
		.clk_in   (clk_in),
		.rdata_in (rdata),
		.req_out  (req)
	);

	// ------------------------------------------------------------------
	// Checking
	// ------------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host.read_byte(a, v);
		check8(v, exp);
	endtask

	// Whole run needs well under a thousand cycles
	always @(posedge clk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			fail_count++;
			close_out();
		end
	end

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic test_defaults();
		read_check(8'h1b, 8'h00);
		read_check(8'h1c, 8'h00);
		read_check(8'h22, 8'h00);
		check8({2'b00, drive}, 8'h00);
		read_check(8'h1a, 8'h00);
		check8(init_byte, 8'h00);
		check8({6'h00, gain_sel, wake_gain}, 8'h03);
	endtask

	task automatic test_identity();
		read_check(8'h18, ID_CODE);
		host.write_byte(8'h18, ~ID_CODE);
		read_check(8'h18, ID_CODE);
		@(posedge clk_in);
		#1 check8(rdata, 8'h00);
		host.write_byte(8'h30, 8'hff);
		read_check(8'h30, 8'h00);
	endtask

	task automatic test_scratchpad();
		logic [7:0] vals [3] = '{8'ha5, 8'h5a, 8'hff};
		for (int i = 0; i < 3; i++)
		begin
			host.write_byte(8'h1b, vals[i]);
			read_check(8'h1b, vals[i]);
			check8({2'b00, wake_lvl, watch_lvl}, 8'h00);
		end
	endtask

	task automatic test_power();
		logic [2:0] codes [3] = '{3'b000, 3'b011, 3'b100};
		logic [2:0] w;
		logic [2:0] s;
		for (int i = 0; i < 3; i++)
		begin
			w = codes[i];
			s = codes[(i + 1) % 3];
			host.write_power(1'b1, s, w);
			read_check(8'h1c, {1'b0, s, 1'b0, w});
			check8({2'b00, wake_lvl, watch_lvl}, {2'b00, w, s});
			check8({5'h00, fast, wake_rsv, watch_rsv}, 8'h04);
			check8({7'h00, fast}, {7'h00, host.fast_shadow});
		end
		host.write_power(1'b0, 3'b111, 3'b101);
		check8({5'h00, fast, wake_rsv, watch_rsv}, 8'h03);
		check8({7'h00, fast}, {7'h00, host.fast_shadow});
	endtask

	task automatic test_drive();
		logic [1:0] d;
		logic [1:0] e;
		for (int i = 0; i < 4; i++)
		begin
			d = i[1:0];
			e = (d == 2'b11) ? 2'b00 : {d[0], d[1]};
			host.write_x(d);
			check8({2'b00, drive}, {2'b00, e, 4'h0});
			read_check(8'h20, 8'h00);
			host.write_x(2'b00);
			host.write_y(d);
			check8({2'b00, drive}, {4'h0, e, 2'b00});
			host.write_y(2'b00);
			host.write_z(d);
			check8({2'b00, drive}, {6'h00, e});
			read_check(8'h22, {4'h0, d, 2'b00});
			host.write_z(2'b00);
		end
	endtask

	task automatic test_mode();
		mode_t modes [6] = '{MODE_SLEEP, MODE_STANDBY, MODE_WATCH,
			MODE_CONTINUOUS_WAKE_MODE, MODE_COMBINED_WAKE_MODE, MODE_TRIGGER};
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk_in);
			mode_sel <= modes[i];
			read_check(8'h21, (i < 2) ? 8'h00 : 8'h80);
		end
		@(posedge clk_in);
		mode_sel <= mode_t'(3'b011);
		read_check(8'h21, 8'h00);
	endtask

	// Reset in mid-run must clear every stored byte
	task automatic test_reset();
		host.write_byte(8'h1b, 8'h3c);
		host.write_power(1'b1, 3'b100, 3'b011);
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		#1 check8({fast, wake_lvl, watch_lvl, 1'b0}, 8'h00);
		check8({drive, gain_sel, wake_gain}, 8'h00);
		check8(init_byte | rdata, 8'h00);
		@(posedge clk_in);
		rst_in <= 1'b0;
		host.start_up();
		read_check(8'h1b, 8'h00);
		read_check(8'h1c, 8'h00);
		check8({6'h00, gain_sel, wake_gain}, 8'h03);
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		host.start_up();
		test_defaults();
		test_identity();
		test_scratchpad();
		test_power();
		test_drive();
		test_reset();
		test_mode();
		close_out();
	end
endmodule
